// [verilog/scs_sequencer.v]
`timescale 1ns/1ps
`include "scs_map.vh"
module scs_sequencer (
	// Clock and reset
	input  wire        core_clk,
	input  wire        rst,
	// Host control
	input  wire        convert_start_n,
	input  wire        coding_select,
	input  wire        interface_sel_hi,
	input  wire        interface_sel_lo,
	// Analog front end
	input  wire        comparator_out,
	input  wire        over_range,
	input  wire        under_range,
	output reg         sample_switch_pos,
	output reg         sample_switch_neg,
	output reg         reference_ground,
	output reg  [17:0] dac_code,
	// Result
	output reg         busy,
	output reg  [17:0] result
);
	// One-hot phases of a conversion.
	localparam [5:0] ST_ACQ    = 6'h01;
	localparam [5:0] ST_WAIT   = 6'h02;
	localparam [5:0] ST_OPEN   = 6'h04;
	localparam [5:0] ST_GROUND = 6'h08;
	localparam [5:0] ST_TRIAL  = 6'h10;
	localparam [5:0] ST_DONE   = 6'h20;

	// Phase and counter.
	reg  [5:0]            state_q;
	reg  [5:0]            state_d;
	reg  [`SCS_CNT_W-1:0] cnt_q;
	reg  [`SCS_CNT_W-1:0] cnt_d;

	// Successive approximation words.
	reg  [17:0]           trial_q;
	reg  [17:0]           trial_d;
	reg  [17:0]           sar_q;
	reg  [17:0]           sar_d;

	// Range flags held for the whole conversion.
	reg                   ovr_q;
	reg                   ovr_d;
	reg                   und_q;
	reg                   und_d;

	// Next values of the output flip-flops.
	reg                   switch_d;
	reg                   ground_d;
	reg  [17:0]           dac_d;
	reg                   busy_d;
	reg  [17:0]           result_d;

	// Start edge detection and coded result.
	reg                   start_n_q;
	wire                  fall;
	wire                  acq_end;
	wire                  settle_end;
	wire [17:0]           coded;

	// True when a phase counter stands on its last count.
	function cnt_hit;
		input [`SCS_CNT_W-1:0] cnt;
		input [`SCS_CNT_W-1:0] last;
		begin
			cnt_hit = (cnt == last);
		end
	endfunction

	// Word after one bit decision: the bit under test stays only when
	// the comparator said the sample reaches it.
	function [17:0] next_sar;
		input [17:0] sar;
		input [17:0] trial;
		input        keep;
		begin
			next_sar = keep ? (sar | trial) : sar;
		end
	endfunction

	// The start pin idles high, so the detector resets high too and no
	// false edge follows reset.
	assign fall       = start_n_q & ~convert_start_n;
	assign acq_end    = cnt_hit(cnt_q, `SCS_ACQ_CYC - 5'h01);
	assign settle_end = cnt_hit(cnt_q, `SCS_SETTLE_CYC);

	scs_coder scs_coder_i (
		.raw_code       (sar_q),
		.over_range     (ovr_q),
		.under_range    (und_q),
		.coding_select  (coding_select),
		.interface_mode ({interface_sel_hi, interface_sel_lo}),
		.out_code       (coded)
	);

	always @* begin
		state_d  = state_q;
		cnt_d    = cnt_q;
		trial_d  = trial_q;
		sar_d    = sar_q;
		ovr_d    = ovr_q;
		und_d    = und_q;
		switch_d = sample_switch_pos;
		ground_d = reference_ground;
		dac_d    = dac_code;
		busy_d   = busy;
		result_d = result;
		case (state_q)
		ST_ACQ: begin
			cnt_d = cnt_q + 5'h01;
			if (acq_end) begin
				cnt_d = {`SCS_CNT_W{1'b0}};
				// A start already low converts at once.
				if (!convert_start_n) begin
					busy_d  = 1'b1;
					state_d = ST_OPEN;
				end else begin
					state_d = ST_WAIT;
				end
			end
		end
		ST_WAIT: begin
			// Only this phase listens for an edge; a start that falls while busy
			// or acquiring counts only if start is still low when acquisition ends.
			if (fall) begin
				busy_d  = 1'b1;
				state_d = ST_OPEN;
			end
		end
		ST_OPEN: begin
			switch_d = 1'b0;
			cnt_d    = cnt_q + 5'h01;
			// Switches must be open before arrays leave the inputs.
			if (settle_end) begin
				cnt_d    = {`SCS_CNT_W{1'b0}};
				ground_d = 1'b1;
				ovr_d    = over_range;
				und_d    = under_range;
				trial_d  = `SCS_MSB_MASK;
				dac_d    = `SCS_MSB_MASK;
				sar_d    = 18'h00000;
				state_d  = ST_GROUND;
			end
		end
		ST_GROUND: begin
			// One quiet cycle lets the comparator settle on the sample.
			state_d = ST_TRIAL;
		end
		ST_TRIAL: begin
			// Keep the trial bit when the comparator stays high.
			sar_d   = next_sar(sar_q, trial_q, comparator_out);
			trial_d = trial_q >> 1;
			dac_d   = next_sar(sar_q, trial_q, comparator_out)
				| (trial_q >> 1);
			if (trial_q[0]) begin
				state_d = ST_DONE;
			end
		end
		ST_DONE: begin
			// Code comes from this sample's own trials only.
			result_d = coded;
			busy_d   = 1'b0;
			ground_d = 1'b0;
			switch_d = 1'b1;
			dac_d    = 18'h00000;
			state_d  = ST_ACQ;
		end
		default: begin
			state_d = ST_ACQ;
		end
		endcase
	end

	// Phase control.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q   <= ST_ACQ;
			cnt_q     <= {`SCS_CNT_W{1'b0}};
			start_n_q <= 1'b1;
		end else begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			start_n_q <= convert_start_n;
		end
	end

	// Approximation words and range flags.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			trial_q <= 18'h00000;
			sar_q   <= 18'h00000;
			ovr_q   <= 1'b0;
			und_q   <= 1'b0;
		end else begin
			trial_q <= trial_d;
			sar_q   <= sar_d;
			ovr_q   <= ovr_d;
			und_q   <= und_d;
		end
	end

	// Outputs come straight from flip-flops so the far side never sees
	// a glitch while the phase decode settles.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sample_switch_pos <= 1'b1;
			sample_switch_neg <= 1'b1;
			reference_ground  <= 1'b0;
			dac_code          <= 18'h00000;
			busy              <= 1'b0;
			result            <= 18'h00000;
		end else begin
			sample_switch_pos <= switch_d;
			sample_switch_neg <= switch_d;
			reference_ground  <= ground_d;
			dac_code          <= dac_d;
			busy              <= busy_d;
			result            <= result_d;
		end
	end
endmodule

// [verilog/scs_map.vh]
// How it works
// - Falling start edge after acquisition starts conversion.
// - Open sample switches, then tie arrays to ground.
// - Eighteen binary trials, MSB first, halving steps.
// - After last trial form code, drop busy.
// - Result belongs to the same sample, no latency.
// - Coding select works except in 18-bit mode.
// - Twos complement is binary with MSB inverted.
// - Over-range input gives maximum end code.
// - Under-range input without over-range gives minimum end code.
// - Start held low at acquisition end converts immediately.
`ifndef SCS_MAP_VH
`define SCS_MAP_VH
`define SCS_NBITS       18
`define SCS_MSB_MASK    18'h20000
`define SCS_MAX_SB      18'h3ffff
`define SCS_MIN_SB      18'h00000
`define SCS_MODE_PAR18  2'h0
// Counts are sized to the phase counter so every compare keeps one width.
`define SCS_ACQ_CYC     5'h0a
`define SCS_SETTLE_CYC  5'h02
`define SCS_CNT_W       5
`endif

// [verilog/scs_coder.v]
`timescale 1ns/1ps
`include "scs_map.vh"
module scs_coder (
	// Raw result and coding controls
	input  wire [17:0] raw_code,
	input  wire        over_range,
	input  wire        under_range,
	input  wire        coding_select,
	input  wire [1:0]  interface_mode,
	// Coded result
	output wire [17:0] out_code
);
	wire [17:0] clamped;
	wire        twos;
	assign clamped = over_range ? `SCS_MAX_SB :
		(under_range ? `SCS_MIN_SB : raw_code);
	// In 18-bit mode the select pin is a data pin, so coding is fixed binary.
	assign twos = ~coding_select &
		(interface_mode != `SCS_MODE_PAR18);
	assign out_code = twos ? (clamped ^ `SCS_MSB_MASK) : clamped;
endmodule

// [testbench/scs_properties.sv]
`timescale 1ns/1ps
module scs_properties (
	// Clock and reset
	input wire        core_clk,
	input wire        rst,
	// Host control
	input wire        convert_start_n,
	input wire        coding_select,
	input wire        interface_sel_hi,
	input wire        interface_sel_lo,
	// Analog front end
	input wire        comparator_out,
	input wire        over_range,
	input wire        under_range,
	input wire        sample_switch_pos,
	input wire        sample_switch_neg,
	input wire        reference_ground,
	input wire [17:0] dac_code,
	// Result
	input wire        busy,
	input wire [17:0] result
);
	// Binary coding is forced in the full-width parallel mode.
	wire bin = coding_select | ~(interface_sel_hi | interface_sel_lo);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	busy_len_a: assert property ($rose(busy) |-> busy[*8] ##1 busy[*8]
		##1 busy[*7] ##1 !busy) else $error("busy length wrong");
	switch_order_a: assert property ($rose(busy) |=>
		$fell(sample_switch_pos) && $fell(sample_switch_neg) &&
		!reference_ground ##2 $rose(reference_ground))
		else $error("switch order wrong");
	msb_first_a: assert property ($rose(reference_ground) |->
		dac_code == 18'h20000) else $error("first trial not msb");
	trial_count_a: assert property ($rose(reference_ground) |->
		##20 $fell(busy)) else $error("trial count wrong");
	over_clamp_a: assert property ($rose(reference_ground) && over_range
		|-> ##20 result == {bin, 17'h1ffff}) else $error("over clamp");
	under_clamp_a: assert property ($rose(reference_ground) && under_range
		&& !over_range |-> ##20 result == {~bin, 17'h00000})
		else $error("under clamp");
	conv_hold_a: assert property (busy && $past(busy) |-> $stable(result)
		&& !sample_switch_pos) else $error("hold broken");
	acq_gap_a: assert property ($fell(busy) |-> !busy[*8])
		else $error("acquisition cut short");
	auto_start_a: assert property ($fell(busy) && !convert_start_n |->
		##[9:12] $rose(busy)) else $error("no automatic start");
	cover property ($rose(reference_ground) && over_range);
	cover property ($rose(reference_ground) && under_range);
	cover property ($fell(busy) && !convert_start_n);
endmodule
bind scs_sequencer scs_properties scs_properties_i (
	.core_clk          (core_clk),
	.rst               (rst),
	.convert_start_n   (convert_start_n),
	.coding_select     (coding_select),
	.interface_sel_hi  (interface_sel_hi),
	.interface_sel_lo  (interface_sel_lo),
	.comparator_out    (comparator_out),
	.over_range        (over_range),
	.under_range       (under_range),
	.sample_switch_pos (sample_switch_pos),
	.sample_switch_neg (sample_switch_neg),
	.reference_ground  (reference_ground),
	.dac_code          (dac_code),
	.busy              (busy),
	.result            (result)
);

// [testbench/scs_afe_model.sv]
`timescale 1ns/1ps
module scs_afe_model (
	input  wire [17:0] dac_code,
	input  wire [17:0] level,
	output wire        comparator_out
);
	// An ideal comparator: the trial bit stays while the sample reaches it.
	assign comparator_out = level >= dac_code;
endmodule

// [testbench/testbench.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
	$display("[FAIL] %0t got %h want %h", $time, a, b); end end
module testbench;
	reg        core_clk = 0, rst = 1, start_n = 1, cs = 1, hi = 0, lo = 1;
	reg        ovr = 0, und = 0;
	reg [17:0] level = 0;
	wire       cmp, busy, sp, sn, gnd;
	wire [17:0] dac, result;
	int        err_count = 0, checks_done = 0, n;
	always #5 core_clk = ~core_clk;
	scs_afe_model scs_afe_model_i (.dac_code(dac), .level(level),
		.comparator_out(cmp));
	scs_sequencer scs_sequencer_i (.core_clk(core_clk), .rst(rst),
		.convert_start_n(start_n), .coding_select(cs),
		.interface_sel_hi(hi), .interface_sel_lo(lo), .comparator_out(cmp),
		.over_range(ovr), .under_range(und), .sample_switch_pos(sp),
		.sample_switch_neg(sn), .reference_ground(gnd), .dac_code(dac),
		.busy(busy), .result(result));
	task test_done;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Waits are bounded so a stuck busy cannot hang the run.
	task wt(input logic v);
		for (n = 0; n < 40 && busy !== v; n++) begin
			@(posedge core_clk);
			#1;
		end
		if (busy !== v) begin
			err_count++;
			$display("[FAIL] %0t busy wait timed out", $time);
			test_done();
		end
	endtask
	task conv(input [17:0] v, input [17:0] e);
		repeat (12) @(posedge core_clk);
		level <= v;
		start_n <= 0;
		wt(1);
		@(posedge core_clk) start_n <= 1;
		wt(0);
		`CHK(result, e)
	endtask
	task t_bin;
		conv(18'h2a5c3, 18'h2a5c3);
		conv(18'h3ffff, 18'h3ffff);
	endtask
	task t_twos;
		@(posedge core_clk) cs <= 0;
		conv(18'h20000, 18'h00000);
		@(posedge core_clk) {hi, lo} <= 2'h0;
		conv(18'h2a5c3, 18'h2a5c3);
	endtask
	task t_range;
		@(posedge core_clk) {ovr, lo} <= 2'h3;
		conv(18'h00000, 18'h1ffff);
		@(posedge core_clk) {ovr, und, cs} <= 3'h3;
		conv(18'h3ffff, 18'h00000);
		@(posedge core_clk) und <= 0;
	endtask
	// A second start edge two cycles into a conversion must change nothing.
	task t_ignore;
		repeat (12) @(posedge core_clk);
		level <= 18'h0f0f1;
		start_n <= 0;
		wt(1);
		@(posedge core_clk) start_n <= 1;
		@(posedge core_clk) start_n <= 0;
		@(posedge core_clk) start_n <= 1;
		wt(0);
		`CHK(n, 20)
		`CHK(result, 18'h0f0f1)
	endtask
	task t_auto;
		repeat (12) @(posedge core_clk);
		level <= 18'h1234f;
		start_n <= 0;
		wt(1);
		wt(0);
		wt(1);
		@(posedge core_clk) start_n <= 1;
		wt(0);
		`CHK(result, 18'h1234f)
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 0;
		t_bin();
		t_twos();
		t_range();
		t_ignore();
		t_auto();
		test_done();
	end
endmodule
